// ---- rtl/smbmr_consts.svh ----
// constants for the battery mode and remaining-time alarm registers
`ifndef SMBMR_CONSTS_SVH
`define SMBMR_CONSTS_SVH

// command codes seen on the command port
`define SMBMR_CMD_TIME_THR   8'h02
`define SMBMR_CMD_MODE       8'h03
`define SMBMR_CMD_RATE_SET   8'h04

// battery mode word field positions
`define SMBMR_RELEARN_BIT    7
`define SMBMR_ONBOARD_BIT    8
`define SMBMR_MAIN_ROLE_BIT  9
`define SMBMR_ALARM_OFF_BIT  13
`define SMBMR_CHG_OFF_BIT    14
`define SMBMR_CAP_UNIT_BIT   15

// reset values
`define SMBMR_MODE_RST       3'h0
`define SMBMR_RELEARN_RST    1'b1
`define SMBMR_THR_OFF        16'h0000

// timing: clock period and one second in ns, cycles derived
`define SMBMR_CLK_NS         8
`define SMBMR_SECOND_NS      1000000000
`define SMBMR_SEC_CYCLES     (`SMBMR_SECOND_NS / `SMBMR_CLK_NS)
`define SMBMR_SUPPRESS_S     60
`define SMBMR_RATE_LIMIT_S   10
`define SMBMR_REFRESH_S      1
`define SMBMR_RELEARN_CYCLES 20

`endif

// ---- rtl/smbmr_pkg.sv ----
// types shared by the battery mode register block
package smbmr_pkg;

  // one command as presented on the link pins
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  cmd;
    logic [15:0] wdata;
  } smbmr_req_t;

  // writable battery mode bits
  typedef struct packed {
    logic cap_unit;
    logic chg_bcast_off;
    logic alarm_bcast_off;
  } smbmr_mode_t;

endpackage : smbmr_pkg

// ---- rtl/smbmr_regs.sv ----
// battery mode word and remaining-time alarm register block
//
// Overview of operation
// - time estimate below threshold sends alert with remaining-time flag set.
// - threshold of zero disables the remaining-time alarm.
// - threshold loads from config flash at start, kept until host writes.
// - threshold is an unsigned 16-bit minute count, read and written as word.
// - mode bits 13-15 read-write, all other bits read-only, bit 7 writes ignored.
// - reserved mode bits 2-6 and 10-12 always read zero.
// - relearn flag set on full reset or 20 cycles unlearned, cleared by learn.
// - onboard charger and main pack role bits always read zero.
// - alarm-off bit stops bus mastering and alerts for 60 s.
// - at most one alert broadcast per 10 s.
// - each mode write restarts 60 s timer; expiry re-enables alerts.
// - sleep entry clears alarm-off, charger-off and capacity-unit bits.
// - alarm-off bit never touches the charger-off bit.
// - charger-off bit stops charge current and voltage requests.
// - capacity-unit bit selects 10 mW/mWh or mA/mAh reporting.
// - capacity-type values use the unit chosen by capacity-unit bit.
// - rate and time estimates, status computed in the chosen unit.
// - unit change updates others at once, rate values on write or 1 s.
`timescale 1ns/1ps
`default_nettype none
`include "smbmr_consts.svh"
module smbmr_regs
  import smbmr_pkg::*;
#(
  parameter logic [31:0] SEC_CYCLES     = 32'(`SMBMR_SEC_CYCLES),
  parameter logic [7:0]  RELEARN_CYCLES = 8'd`SMBMR_RELEARN_CYCLES
) (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // link pins from the serial bus engine
  input  wire logic        smb_clk,
  input  wire smbmr_req_t  smb_req,
  // read answer
  output logic [15:0]      rd_data,
  output logic             rd_ack,
  // gauge side inputs
  input  wire logic [15:0] cfg_time_thr,
  input  wire logic [15:0] avg_runtime_estimate,
  input  wire logic        sleep_enter,
  input  wire logic        full_reset,
  input  wire logic        cycle_count_inc,
  input  wire logic        fcc_update,
  input  wire logic        learn_done,
  // alert and broadcast control
  output logic             alert_message_req,
  output logic             alert_time_flag,
  output logic             master_allowed,
  output logic             charge_request_en,
  // unit selection and recalculation
  output logic             capacity_unit,
  output logic             unit_recalc,
  output logic             rate_recalc
);
  logic        rst_s1;
  logic        rst_n;
  logic        lclk_q2;
  logic        lclk_q3;
  logic        lclk_state;
  smbmr_req_t  req_q3;
  logic        lclk_rise;
  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  cmd_reg;
  logic [15:0] wdata_reg;
  logic [15:0] thr_reg;
  logic        thr_init_reg;
  smbmr_mode_t mode_reg;
  smbmr_mode_t mode_next;
  logic        relearn_reg;
  logic [7:0]  unlearn_reg;
  logic        sup_active;
  logic        sup_done;
  logic        lim_active;
  logic        refresh_tick;
  logic        refresh_active;
  logic        alarm_cond;
  logic        send_now;
  logic        rate_pend_reg;

  // reset release through two flip-flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // link clock and request pins synchronised
  smbmr_sync #(.W(1)) u_sync_clk (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .din   (smb_clk),
    .q2    (lclk_q2),
    .q3    (lclk_q3)
  );

  smbmr_sync #(.W($bits(smbmr_req_t))) u_sync_req (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .din   (smb_req),
    .q2    (),
    .q3    (req_q3)
  );

  // link edge counts once the late stages agree
  assign lclk_rise = (lclk_q2 == lclk_q3) && lclk_q3 && !lclk_state;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lclk_state <= 1'b0;
    end else if (ce) begin
      if (lclk_q2 == lclk_q3) begin
        lclk_state <= lclk_q3;
      end
    end
  end

  // capture a command at the link rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_stb    <= 1'b0;
      rd_stb    <= 1'b0;
      cmd_reg   <= 8'h00;
      wdata_reg <= 16'h0000;
    end else if (ce) begin
      wr_stb <= lclk_rise && req_q3.wr;
      rd_stb <= lclk_rise && req_q3.rd && !req_q3.wr;
      if (lclk_rise) begin
        cmd_reg   <= req_q3.cmd;
        wdata_reg <= req_q3.wdata;
      end
    end
  end

  // remaining-time threshold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_reg      <= `SMBMR_THR_OFF;
      thr_init_reg <= 1'b0;
    end else if (ce) begin
      if (!thr_init_reg) begin
        thr_reg      <= cfg_time_thr;
        thr_init_reg <= 1'b1;
      end else if (wr_stb && cmd_reg == `SMBMR_CMD_TIME_THR) begin
        thr_reg <= wdata_reg;
      end
    end
  end

  // next mode bits from a host write
  always_comb begin
    mode_next = mode_reg;
    if (wr_stb && cmd_reg == `SMBMR_CMD_MODE) begin
      mode_next.cap_unit        = wdata_reg[`SMBMR_CAP_UNIT_BIT];
      mode_next.chg_bcast_off   = wdata_reg[`SMBMR_CHG_OFF_BIT];
      mode_next.alarm_bcast_off = wdata_reg[`SMBMR_ALARM_OFF_BIT];
    end
    if (sup_done) begin
      mode_next.alarm_bcast_off = 1'b0;
    end
    if (sleep_enter) begin
      mode_next = `SMBMR_MODE_RST;
    end
  end

  // mode register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= `SMBMR_MODE_RST;
    end else if (ce) begin
      mode_reg <= mode_next;
    end
  end

  // suppression window, restarted by every mode write
  // host rewrite keeps it alive
  smbmr_sec_timer #(
    .SEC_CYCLES (SEC_CYCLES),
    .SECS       (8'd`SMBMR_SUPPRESS_S)
  ) u_suppress (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .restart (wr_stb && cmd_reg == `SMBMR_CMD_MODE),
    .active  (sup_active),
    .done    (sup_done)
  );

  // gap timer after each alert broadcast
  smbmr_sec_timer #(
    .SEC_CYCLES (SEC_CYCLES),
    .SECS       (8'd`SMBMR_RATE_LIMIT_S)
  ) u_limit (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .restart (send_now),
    .active  (lim_active),
    .done    ()
  );

  // free-running one second refresh
  smbmr_sec_timer #(
    .SEC_CYCLES (SEC_CYCLES),
    .SECS       (8'd`SMBMR_REFRESH_S)
  ) u_refresh (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .restart (!refresh_active),
    .active  (refresh_active),
    .done    (refresh_tick)
  );

  // relearn request and unlearned cycle count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      relearn_reg <= `SMBMR_RELEARN_RST;
      unlearn_reg <= 8'h00;
    end else if (ce) begin
      if (fcc_update || learn_done) begin
        unlearn_reg <= 8'h00;
      end else if (cycle_count_inc && unlearn_reg != RELEARN_CYCLES) begin
        unlearn_reg <= unlearn_reg + 8'd1;
      end
      if (full_reset || (cycle_count_inc &&
          unlearn_reg == RELEARN_CYCLES - 8'd1 && !fcc_update)) begin
        relearn_reg <= 1'b1;
      end else if (learn_done) begin
        relearn_reg <= 1'b0;
      end
    end
  end

  assign alarm_cond = (thr_reg != `SMBMR_THR_OFF) &&
                      (avg_runtime_estimate < thr_reg);

  assign send_now = alarm_cond && !mode_reg.alarm_bcast_off &&
                    !lim_active && !alert_message_req;

  // alert requests and bus mastering permission
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_message_req <= 1'b0;
      alert_time_flag   <= 1'b0;
      master_allowed    <= 1'b1;
    end else if (ce) begin
      alert_message_req <= send_now;
      alert_time_flag   <= alarm_cond;
      master_allowed    <= !mode_next.alarm_bcast_off;
    end
  end

  // charger broadcast and unit outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_request_en <= 1'b1;
      capacity_unit     <= 1'b0;
    end else if (ce) begin
      charge_request_en <= !mode_next.chg_bcast_off;
      capacity_unit     <= mode_next.cap_unit;
    end
  end

  // recalculation requests after a unit change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_recalc   <= 1'b0;
      rate_recalc   <= 1'b0;
      rate_pend_reg <= 1'b0;
    end else if (ce) begin
      unit_recalc <= mode_next.cap_unit != mode_reg.cap_unit;
      rate_recalc <= 1'b0;
      if (mode_next.cap_unit != mode_reg.cap_unit) begin
        rate_pend_reg <= 1'b1;
      end else if (rate_pend_reg && (refresh_tick ||
          (wr_stb && cmd_reg == `SMBMR_CMD_RATE_SET))) begin
        // rate values on write or tick
        rate_pend_reg <= 1'b0;
        rate_recalc   <= 1'b1;
      end
    end
  end

  // read answer, one cycle after the captured command
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
      rd_ack  <= 1'b0;
    end else if (ce) begin
      rd_ack <= 1'b0;
      if (rd_stb) begin
        if (cmd_reg == `SMBMR_CMD_TIME_THR) begin
          rd_data <= thr_reg;
          rd_ack  <= 1'b1;
        end else if (cmd_reg == `SMBMR_CMD_MODE) begin
          rd_data <= 16'h0000;
          rd_data[`SMBMR_CAP_UNIT_BIT]  <= mode_reg.cap_unit;
          rd_data[`SMBMR_CHG_OFF_BIT]   <= mode_reg.chg_bcast_off;
          rd_data[`SMBMR_ALARM_OFF_BIT] <= mode_reg.alarm_bcast_off;
          rd_data[`SMBMR_RELEARN_BIT]   <= relearn_reg;
          rd_ack  <= 1'b1;
        end
      end
    end
  end

endmodule : smbmr_regs
`default_nettype wire

// ---- rtl/smbmr_sec_timer.sv ----
// restartable timer counting whole seconds
`timescale 1ns/1ps
`default_nettype none
module smbmr_sec_timer #(
  parameter logic [31:0] SEC_CYCLES = 32'd125000000,
  parameter logic [7:0]  SECS       = 8'd60
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // control and status
  input  wire logic restart,
  output logic      active,
  output logic      done
);
  logic [31:0] pre_reg;
  logic [7:0]  sec_reg;
  logic        wrap;

  assign wrap = (pre_reg == SEC_CYCLES - 32'd1);

  // prescaler and second count, restart wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 32'h0;
      sec_reg <= 8'h0;
      active  <= 1'b0;
      done    <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (restart) begin
        pre_reg <= 32'h0;
        sec_reg <= 8'h0;
        active  <= 1'b1;
      end else if (active) begin
        pre_reg <= wrap ? 32'h0 : pre_reg + 32'd1;
        if (wrap) begin
          sec_reg <= sec_reg + 8'd1;
          if (sec_reg == SECS - 8'd1) begin
            active <= 1'b0;
            done   <= 1'b1;
          end
        end
      end
    end
  end
endmodule : smbmr_sec_timer
`default_nettype wire

// ---- rtl/smbmr_sync.sv ----
// three-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module smbmr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // pin in, late stages out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] q2,
  output logic      [W-1:0] q3
);
  logic [W-1:0] q1;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q1 <= '0;
      q2 <= '0;
      q3 <= '0;
    end else if (ce) begin
      q1 <= din;
      q2 <= q1;
      q3 <= q2;
    end
  end
endmodule : smbmr_sync
`default_nettype wire

// ---- test/smbmr_host.sv ----
// host model sending command frames on the link pins
`timescale 1ns/1ps
`default_nettype none
module smbmr_host
  import smbmr_pkg::*;
(
  // clock and read answer
  input  wire logic        clk,
  input  wire logic        rd_ack,
  input  wire logic [15:0] rd_data,
  // link pins
  output var logic         smb_clk,
  output var smbmr_req_t   smb_req
);
  int          acks;
  logic [15:0] rdv;
  // idle link at time zero
  initial begin
    smb_clk = 1'b0;
    smb_req = '0;
    acks    = 0;
  end
  // capture each read answer
  always @(posedge clk) begin
    if (rd_ack === 1'b1) begin
      rdv  <= rd_data;
      acks <= acks + 1;
    end
  end
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [15:0] d);
    smb_req = '{wr: w, rd: !w, cmd: c, wdata: d};
    #35 smb_clk = 1'b1;
    #32 smb_clk = 1'b0;
    smb_req = ~smb_req;
    #8;
  endtask : xfer
endmodule : smbmr_host
`default_nettype wire

// ---- test/smbmr_regs_checker.sv ----
// assertion checker for the battery mode register block
`timescale 1ns/1ps
`default_nettype none
module smbmr_regs_checker
  import smbmr_pkg::*;
#(
  parameter logic [31:0] SEC_CYCLES = 32'd20
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // watched ports
  input wire logic [15:0] rd_data,
  input wire logic        rd_ack,
  input wire logic        sleep_enter,
  input wire logic        alert_message_req,
  input wire logic        alert_time_flag,
  input wire logic        master_allowed,
  input wire logic        charge_request_en,
  input wire logic        capacity_unit,
  input wire logic        unit_recalc,
  input wire logic        rate_recalc
);
  localparam int RWIN = int'(SEC_CYCLES) + 2;
  localparam int GAP  = 10 * int'(SEC_CYCLES);
  int   gap_cnt;
  logic seen;
  int   rw_cnt;
  logic rw_pend;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // cycles since the last alert pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_cnt <= 0;
      seen    <= 1'b0;
    end else if (alert_message_req) begin
      gap_cnt <= 1;
      seen    <= 1'b1;
    end else if (gap_cnt < GAP) begin
      gap_cnt <= gap_cnt + 1;
    end
  end
  // cycles a rate recalc has been owed since a unit change
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rw_cnt  <= 0;
      rw_pend <= 1'b0;
    end else if (unit_recalc) begin
      rw_cnt  <= 0;
      rw_pend <= 1'b1;
    end else if (rate_recalc) begin
      rw_pend <= 1'b0;
    end else if (rw_pend) begin
      rw_cnt <= rw_cnt + 1;
    end
  end
  property p_ack_pulse;
    rd_ack |=> !rd_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("read answer longer than one cycle");
  property p_rd_hold;
    !rd_ack |-> $stable(rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without an answer");
  property p_alert_flag;
    alert_message_req |-> alert_time_flag;
  endproperty
  a_alert_flag: assert property (p_alert_flag)
    else $error("alert without remaining-time flag");
  property p_alert_off;
    alert_message_req |-> $past(master_allowed);
  endproperty
  a_alert_off: assert property (p_alert_off)
    else $error("alert while broadcasts disabled");
  property p_alert_gap;
    alert_message_req && seen |-> gap_cnt >= GAP;
  endproperty
  a_alert_gap: assert property (p_alert_gap)
    else $error("alerts closer than the minimum gap");
  property p_unit_recalc;
    unit_recalc == $changed(capacity_unit);
  endproperty
  a_unit_recalc: assert property (p_unit_recalc)
    else $error("unit recalc not tied to unit change");
  property p_rate_win;
    rw_pend |-> rw_cnt < RWIN;
  endproperty
  a_rate_win: assert property (p_rate_win)
    else $error("rate recalc late after unit change");
  property p_sleep;
    sleep_enter |=> !capacity_unit && master_allowed && charge_request_en;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("mode bits not cleared on sleep");
endmodule : smbmr_regs_checker

bind smbmr_regs smbmr_regs_checker #(.SEC_CYCLES(SEC_CYCLES)) u_chk (
  .clk(clk), .arst_n(arst_n), .rd_data(rd_data), .rd_ack(rd_ack),
  .sleep_enter(sleep_enter), .alert_message_req(alert_message_req),
  .alert_time_flag(alert_time_flag), .master_allowed(master_allowed),
  .charge_request_en(charge_request_en), .capacity_unit(capacity_unit),
  .unit_recalc(unit_recalc), .rate_recalc(rate_recalc)
);
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the battery mode register block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import smbmr_pkg::*;
  localparam int S = 20;
  logic        clk, arst_n, smb_clk, rd_ack, alert_message_req;
  logic        alert_time_flag, master_allowed, charge_request_en;
  logic        capacity_unit, unit_recalc, rate_recalc, m_rel;
  logic [4:0]  ev;
  logic [2:0]  m_mode;
  logic [15:0] cfg_thr, est, rd_data, m_thr;
  logic [31:0] lfsr;
  smbmr_req_t  smb_req;
  int          mismatches, checked, alerts, a0, i, k;
  // design and host model
  smbmr_regs #(.SEC_CYCLES(32'(S))) u_dut (
    .clk(clk), .arst_n(arst_n), .ce(1'b1), .smb_clk(smb_clk),
    .smb_req(smb_req), .rd_data(rd_data), .rd_ack(rd_ack),
    .cfg_time_thr(cfg_thr), .avg_runtime_estimate(est),
    .sleep_enter(ev[0]), .full_reset(ev[1]), .cycle_count_inc(ev[2]),
    .fcc_update(ev[3]), .learn_done(ev[4]),
    .alert_message_req(alert_message_req),
    .alert_time_flag(alert_time_flag), .master_allowed(master_allowed),
    .charge_request_en(charge_request_en), .capacity_unit(capacity_unit),
    .unit_recalc(unit_recalc), .rate_recalc(rate_recalc));
  smbmr_host u_host (.clk(clk), .rd_ack(rd_ack), .rd_data(rd_data),
    .smb_clk(smb_clk), .smb_req(smb_req));
  // clock source
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // alert pulse count
  always @(posedge clk) begin
    if (alert_message_req === 1'b1) alerts <= alerts + 1;
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  function automatic logic [15:0] em();
    return {m_mode, 5'h00, m_rel, 7'h00};
  endfunction : em
  task automatic give_verdict();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo();
    chk(16'h0001, 16'h0000);
    give_verdict();
  endtask : tmo
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk);
    u_host.xfer(1'b1, c, d);
    if (c == 8'h03) m_mode = d[15:13];
    if (c == 8'h02) m_thr = d;
    repeat (8) @(negedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    int n;
    n = u_host.acks;
    @(negedge clk);
    u_host.xfer(1'b0, c, 16'h0000);
    for (k = 0; k < 20 && u_host.acks == n; k++) @(negedge clk);
    if (k == 20) begin
      tmo();
    end else begin
      chk(u_host.rdv, exp);
    end
  endtask : rd
  task automatic lvl();
    chk({13'h0, capacity_unit, charge_request_en, master_allowed},
        {13'h0, m_mode[2], ~m_mode[1], ~m_mode[0]});
  endtask : lvl
  task automatic pls(input int b);
    @(negedge clk);
    ev[b] = 1'b1;
    @(negedge clk);
    ev[b] = 1'b0;
  endtask : pls
  // main sequence
  initial begin
    arst_n = 1'b0;
    ev = '0;
    est = 16'hffff;
    {mismatches, checked, alerts} = '0;
    lfsr = 32'h86ba;
    cfg_thr = lfsr[15:0];
    m_mode = 3'h0;
    m_rel = 1'b1;
    m_thr = cfg_thr;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    rd(8'h02, m_thr);
    rd(8'h03, em());
    wr(8'h03, 16'hffff);
    rd(8'h03, em());
    lvl();
    for (i = 0; i < 3; i++) begin
      lfsr = nxt(lfsr);
      wr(8'h02, (i == 0) ? 16'hffff : lfsr[15:0]);
      wr(8'h05, lfsr[31:16]);
      rd(8'h02, m_thr);
    end
    wr(8'h03, 16'h6000);
    repeat (50 * S) @(negedge clk);
    wr(8'h03, 16'h6000);
    repeat (58 * S) @(negedge clk);
    lvl();
    for (k = 0; k < 3 * S && master_allowed !== 1'b1; k++) @(negedge clk);
    if (k == 3 * S) tmo();
    m_mode[0] = 1'b0;
    lvl();
    rd(8'h03, em());
    wr(8'h02, 16'h0000);
    est = 16'h0000;
    a0 = alerts;
    repeat (3 * S) @(negedge clk);
    chk(16'(alerts - a0), 16'h0000);
    a0 = alerts;
    wr(8'h02, 16'h0064);
    repeat (24 * S) @(negedge clk);
    chk(16'(alerts - a0), 16'h0003);
    chk(alert_time_flag, 1'b1);
    wr(8'h03, 16'h2000);
    a0 = alerts;
    repeat (15 * S) @(negedge clk);
    chk(16'(alerts - a0), 16'h0000);
    wr(8'h03, 16'he000);
    wr(8'h04, 16'h0001);
    lvl();
    pls(0);
    m_mode = 3'h0;
    lvl();
    rd(8'h03, em());
    pls(4);
    m_rel = 1'b0;
    for (i = 0; i < 19; i++) pls(2);
    pls(3);
    for (i = 0; i < 19; i++) pls(2);
    rd(8'h03, em());
    pls(2);
    m_rel = 1'b1;
    rd(8'h03, em());
    pls(4);
    pls(1);
    rd(8'h03, em());
    give_verdict();
  end
endmodule : tb
`default_nettype wire
